// >>> hdl/tpc_defines.svh
// constants for the timer and pwm compare block
`ifndef TPC_DEFINES_SVH
`define TPC_DEFINES_SVH

// prescaler terminal counts (ratio minus one)
`define TPC_PS_LIM_1    8'h00
`define TPC_PS_LIM_8    8'h07
`define TPC_PS_LIM_64   8'h3f
`define TPC_PS_LIM_256  8'hff

// input clock edges seen while disabled before the prescaler clears
`define TPC_CLR_EDGES   2'h2

// reset values
`define TPC_RST_PS      8'h00
`define TPC_RST_EDGES   2'h0

`endif

// >>> hdl/tpc_pkg.sv
// types for the timer and pwm compare block
package tpc_pkg;

	typedef enum logic [1:0]
	{
		TPC_DIV_1   = 2'h0,
		TPC_DIV_8   = 2'h1,
		TPC_DIV_64  = 2'h2,
		TPC_DIV_256 = 2'h3
	} tpc_presc_t;

endpackage

// >>> hdl/tpc_sync3.sv
// three-stage pin synchroniser with agreement filter and rise pulse
`timescale 1ns/100ps

module tpc_sync3
(
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	input  wire logic pin_i,
	output logic      level_o,
	output logic      rise_o
);

	logic stage1;
	logic stage2;
	logic stage3;

	// stage1 feeds stage2 only
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			stage1  <= 1'b0;
			stage2  <= 1'b0;
			stage3  <= 1'b0;
			level_o <= 1'b0;
		end
		else
		begin
			stage1 <= pin_i;
			stage2 <= stage1;
			stage3 <= stage2;
			if (stage2 == stage3)
				level_o <= stage3;
		end
	end

	assign rise_o = (stage2 == stage3) & stage3 & ~level_o;

endmodule // tpc_sync3

// >>> hdl/tpc_timer_pwm.sv
// timer counter with prescaler, period match and pwm compare output
//
// Notes on behaviour
// - period zero: count holds zero two ticks
// - quick disable/enable keeps stale prescaler count
// - first timer prescaler has same stale count
// - duty zero then one gives full-period high in pwm mode
`timescale 1ns/100ps
`include "tpc_defines.svh"

module tpc_timer_pwm
	import tpc_pkg::*;
#(
	parameter int CNT_W       = 16,
	parameter bit FIRST_TIMER = 1'b0
)
(
	input  wire logic             clk_i,
	input  wire logic             reset_n_i,
	input  wire logic             enable_i,
	input  wire logic             ext_clk_sel_i,
	input  wire logic             ext_clk_i,
	input  wire tpc_presc_t       prescale_sel_i,
	input  wire logic [CNT_W-1:0] period_value_i,
	input  wire logic             pwm_mode_i,
	input  wire logic [CNT_W-1:0] duty_i,
	output logic      [CNT_W-1:0] timer_count_o,
	output logic                  period_match_o,
	output logic                  compare_o
);

	////////////////////////////////////////////////////////////////////////////
	// input clock source and prescaler

	logic             ext_rise;
	logic             src_edge;
	logic [7:0]       presc_cnt;
	logic [7:0]       presc_lim;
	logic [1:0]       dis_edges;
	logic             presc_clr;
	logic             presc_hit;
	logic             tick;

	tpc_sync3 u_ext_sync
	(
		.clk_i     (clk_i),
		.reset_n_i (reset_n_i),
		.pin_i     (ext_clk_i),
		.level_o   (),
		.rise_o    (ext_rise)
	);

	assign src_edge  = ext_clk_sel_i ? ext_rise : 1'b1;
	assign presc_lim = (prescale_sel_i == TPC_DIV_1)  ? `TPC_PS_LIM_1  :
	                   (prescale_sel_i == TPC_DIV_8)  ? `TPC_PS_LIM_8  :
	                   (prescale_sel_i == TPC_DIV_64) ? `TPC_PS_LIM_64 : `TPC_PS_LIM_256;
	// clearing needs input clock edges; a slow source re-enabled early keeps its count
	assign presc_clr = ~enable_i & (dis_edges == `TPC_CLR_EDGES);
	assign presc_hit = presc_cnt >= presc_lim;
	assign tick      = enable_i & src_edge & presc_hit;

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			dis_edges <= `TPC_RST_EDGES;
		else if (enable_i)
			dis_edges <= `TPC_RST_EDGES;
		else if (src_edge && dis_edges != `TPC_CLR_EDGES)
			dis_edges <= dis_edges + 2'h1;
	end

	// the same path serves the first timer; no bypass exists for it
	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			presc_cnt <= `TPC_RST_PS;
		else if (presc_clr)
			presc_cnt <= `TPC_RST_PS;
		else if (enable_i && src_edge)
			presc_cnt <= presc_hit ? `TPC_RST_PS : presc_cnt + 8'h01;
	end

	////////////////////////////////////////////////////////////////////////////
	// counter and period match

	logic             zero_hold;
	logic             cnt_match;
	logic             wrap;

	assign cnt_match = timer_count_o == period_value_i;
	// a zero period needs a second tick at zero before it wraps
	assign wrap      = cnt_match & ((period_value_i != '0) | zero_hold);

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			timer_count_o  <= '0;
			zero_hold      <= 1'b0;
			period_match_o <= 1'b0;
		end
		else
		begin
			period_match_o <= tick & wrap;
			if (tick)
			begin
				if (wrap)
				begin
					timer_count_o <= '0;
					zero_hold     <= 1'b0;
				end
				else if (cnt_match)
					zero_hold     <= 1'b1;
				else
					timer_count_o <= timer_count_o + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// compare output

	logic [CNT_W-1:0] duty_act;
	logic             full_high;
	logic             load_duty;
	logic             bad_seq;

	assign load_duty = (tick & wrap) | ~enable_i;
	// in pwm mode, zero followed by one wrongly drives a whole high period
	assign bad_seq   = (duty_act == '0) & (duty_i == {{(CNT_W-1){1'b0}}, 1'b1});

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			duty_act  <= '0;
			full_high <= 1'b0;
		end
		else if (load_duty)
		begin
			duty_act  <= duty_i;
			full_high <= bad_seq & enable_i;
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			compare_o <= 1'b0;
		else if (pwm_mode_i)
			compare_o <= full_high | (timer_count_o < duty_act);
		else
			compare_o <= timer_count_o >= duty_i;
	end

	////////////////////////////////////////////////////////////////////////////
	// assertions

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);

	property p_zero_two;
		tick && period_value_i == '0 && !zero_hold
			|=> zero_hold && timer_count_o == '0 && !period_match_o;
	endproperty
	a_zero_two: assert property (p_zero_two) else $error("zero period wrapped early");

	property p_stale_keep;
		!enable_i && !presc_clr |=> presc_cnt == $past(presc_cnt);
	endproperty
	a_stale_keep: assert property (p_stale_keep) else $error("prescaler moved");

	property p_clear;
		presc_clr |=> presc_cnt == `TPC_RST_PS;
	endproperty
	a_clear: assert property (p_clear) else $error("prescaler not cleared");

	property p_step;
		tick && !cnt_match |=> timer_count_o == $past(timer_count_o) + 1'b1;
	endproperty
	a_step: assert property (p_step) else $error("count did not step");

	property p_wrap;
		tick && wrap |=> timer_count_o == '0 && period_match_o;
	endproperty
	a_wrap: assert property (p_wrap) else $error("count did not wrap");

	property p_full;
		tick && wrap && enable_i && bad_seq |=> full_high;
	endproperty
	a_full: assert property (p_full) else $error("full period high missing");

	property p_full_out;
		full_high && pwm_mode_i |=> compare_o;
	endproperty
	a_full_out: assert property (p_full_out) else $error("compare not high");

	// a wrap needs at least two ticks, so the pulse never doubles
	property p_match_once;
		period_match_o |=> !period_match_o;
	endproperty
	a_match_once: assert property (p_match_once) else $error("match pulse too long");

	// disabling freezes the count; only the prescaler may clear
	property p_hold_off;
		!enable_i |=> timer_count_o == $past(timer_count_o);
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("count moved while off");

	property p_zero_wrap;
		tick && period_value_i == '0 && zero_hold && timer_count_o == '0
			|=> period_match_o && !zero_hold && timer_count_o == '0;
	endproperty
	a_zero_wrap: assert property (p_zero_wrap) else $error("zero period second tick");

	property p_cmp_mode;
		!pwm_mode_i |=> compare_o == ($past(timer_count_o) >= $past(duty_i));
	endproperty
	a_cmp_mode: assert property (p_cmp_mode) else $error("compare level wrong");

	c_zero_period: cover property (tick && period_value_i == '0 && zero_hold);
	c_stale:       cover property (!enable_i && dis_edges == 2'h1 ##1 enable_i);
	c_full_high:   cover property (full_high && pwm_mode_i);
	c_clean_clear: cover property (presc_clr ##1 enable_i);

endmodule // tpc_timer_pwm

// >>> testbench/tb_top.sv
// self-checking bench for the timer and pwm compare block
`timescale 1ns/100ps
module tb_top
	import tpc_pkg::*;
;
	logic        clk = 0, rst_n = 0, en = 0, xsel = 0, pwm = 0, match, cmp;
	logic [2:0]  xc = 0;
	logic [7:0]  lf = 8'h3f;
	logic [15:0] per = 16'h0004, duty = 16'h0000, cnt;
	tpc_presc_t  ps = TPC_DIV_1;
	int          err_count = 0, tests_run = 0, gap = 0, run = 0, qg[$], qr[$];
	int          dv[4] = '{1, 8, 64, 256};

	tpc_timer_pwm #(.CNT_W(16), .FIRST_TIMER(1'b1)) i_dut
	(
		.clk_i(clk), .reset_n_i(rst_n), .enable_i(en), .ext_clk_sel_i(xsel),
		.ext_clk_i(xc[2]), .prescale_sel_i(ps), .period_value_i(per), .pwm_mode_i(pwm),
		.duty_i(duty), .timer_count_o(cnt), .period_match_o(match), .compare_o(cmp)
	);

	initial forever #2 clk = ~clk;
	// slow external clock, eight system cycles a period
	always @(posedge clk) xc <= xc + 3'h1;

	function automatic logic [7:0] nx(logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	task automatic chk(string nm, int ex, int sn);
		tests_run++;
		if (ex !== sn)
		begin
			err_count++;
			$display("unexpected %s expected %0d seen %0d", nm, ex, sn);
		end
	endtask

	always @(posedge clk)
	begin
		gap <= (match === 1'b1) ? 1 : gap + 1;
		run <= (cmp === 1'b1) ? run + 1 : 0;
		if (match === 1'b1 && qg.size() > 0) chk("gap", qg.pop_front(), gap);
		if (match === 1'b1) chk("count", 0, (^cnt === 1'bx) ? -1 : int'(cnt));
		if (cmp === 1'b0 && run > 0 && qr.size() > 0) chk("run", qr.pop_front(), run);
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic waitp();
		int w;
		w = 0;
		do
		begin
			@(posedge clk);
			w++;
		end
		while (match !== 1'b1 && w < 9000);
		if (w >= 9000) err_count++;
	endtask

	task automatic drain();
		int w;
		w = 0;
		while (qg.size() + qr.size() > 0 && w < 40000)
		begin
			@(posedge clk);
			w++;
		end
		if (w >= 40000) err_count++;
	endtask

	// config changes right after a wrap, so a lower period never sees a higher count
	task automatic tgap(logic [15:0] p, tpc_presc_t s, logic x);
		int e;
		e = (p == 16'h0000 ? 2 : int'(p) + 1) * (x ? 8 : 1) * dv[s];
		waitp();
		per <= p;
		ps <= s;
		xsel <= x;
		waitp();
		waitp();
		@(negedge clk);
		repeat (3) qg.push_back(e);
		drain();
	endtask

	task automatic trun(logic [15:0] d, logic m, int e);
		int h;
		h = 0;
		waitp();
		duty <= d;
		pwm <= m;
		waitp();
		waitp();
		if (e > 0)
		begin
			@(negedge clk);
			repeat (2) qr.push_back(e);
			drain();
		end
		else
		begin
			// in pwm mode a zero duty never raises the output, so no run ever ends
			repeat (20)
			begin
				@(posedge clk);
				h += int'(cmp !== 1'b0);
			end
			chk("low", 0, h);
		end
	endtask

	initial
	begin
		logic [15:0] p, d;
		repeat (5) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		en <= 1;
		for (int i = 0; i < 4; i++)
		begin
			lf = nx(lf);
			tgap(16'(lf[2:0]) + 16'h0001, tpc_presc_t'(i), 1'b0);
		end
		tgap(16'h0000, TPC_DIV_8, 1'b0);
		tgap(16'h0000, TPC_DIV_1, 1'b1);
		lf = nx(lf);
		p = 16'(lf[2:0]) + 16'h0004;
		tgap(p, TPC_DIV_1, 1'b1);
		tgap(p, TPC_DIV_8, 1'b0);
		waitp();
		@(negedge clk);
		qg.push_back((int'(p) + 1) * 8 + 1);
		repeat (3) @(posedge clk);
		en <= 0;
		@(posedge clk);
		en <= 1;
		drain();
		// off for three clocks: prescaler cleared, three stalled plus four lost counts
		waitp();
		@(negedge clk);
		qg.push_back((int'(p) + 1) * 8 + 7);
		repeat (3) @(posedge clk);
		en <= 0;
		repeat (3) @(posedge clk);
		en <= 1;
		drain();
		tgap(p, TPC_DIV_1, 1'b0);
		lf = nx(lf);
		d = 16'h0002 + 16'(lf[7:4]) % (p - 16'h0002);
		trun(d, 1'b1, int'(d));
		trun(d, 1'b0, int'(p) + 1 - int'(d));
		trun(16'h0000, 1'b1, 0);
		waitp();
		duty <= 16'h0001;
		@(negedge clk);
		qr.push_back(int'(p) + 1);
		waitp();
		duty <= 16'h0000;
		drain();
		end_sim();
	end

	initial
	begin
		#300000;
		err_count++;
		end_sim();
	end
endmodule // tb_top
